// ==== core/pm_sleep_defines.svh ====
// Field positions, reset values and timing constants of the sleep policy block
`ifndef PM_SLEEP_DEFINES_SVH
`define PM_SLEEP_DEFINES_SVH
`define B_S4_VIOL 18
`define B_SUS_FAIL 16
`define B_S5_BLOCK 15
`define B_TRICKLE 14
`define B_DIS_UP 12
`define F_S3W 11:10
`define B_HOST_RST 9
`define B_ESPI_LOCK 8
`define F_S4W 5:4
`define B_S4_STR 3
`define F_SMI 2:1
`define B_AG3 0
`define SUS_FAIL_RST 1'h1
`define TRICKLE_RST 1'h1
`define S4W_RST 2'h0
`define SYNC_RST 5'h07
`define NCH 5
`define CH_S3 0
`define CH_S4 1
`define CH_AUX 2
`define CH_LAN 3
`define CH_SUS 4
`define PIN_RSM 0
`define PIN_RTC 1
`define PIN_DSW 2
`define PIN_TRK 3
`define PIN_HOST 4
`define CLK_MHZ 50
`define TICK_US 10
`define TICK_CYC (`TICK_US * `CLK_MHZ)
`define US_TICKS(us) (((us) + `TICK_US - 1) / `TICK_US)
`define S_TICKS(s) ((s) * 1000000 / `TICK_US)
`define S3W_0_US 60
`define S3W_1_MS 1
`define S3W_2_MS 50
`define S3W_3_S 2
`define S4W_11_S 1
`define S4W_10_S 2
`define S4W_01_S 3
`define S4W_00_S 4
`define SMI_00_S 64
`define SMI_01_S 32
`define SMI_10_S 16
`define SMI_11_S 8
`define DIV_W 16
`define CNT_W 19
`define SMI_W 23
`endif

// ==== core/pm_sleep_pkg.sv ====
// Shared types of the sleep policy block
`default_nettype none
package pm_sleep_pkg;
    typedef enum logic [2:0] {PS_S0 = 3'h0, PS_S1 = 3'h1, PS_S3 = 3'h2, PS_S4 = 3'h3, PS_S5 = 3'h4} pwr_state_e;
    typedef enum logic [1:0] {TGT_S0 = 2'h0, TGT_S5 = 2'h1, TGT_S4 = 2'h2} g3_target_e;
endpackage
`default_nettype wire

// ==== core/pm_sleep_policy_status.sv ====
// Sleep signal width policy, power-fail status, wake policy and periodic SMI
// How it works
// - Flag s4 width violation when sleep_s4 assertion ends before programmed minimum.
// - S4 timer starts at sleep_s4 assertion or resume reset release.
// - Violation flag clears on write of one and on resume reset.
// - Suspend power failure flag sets on resume reset, default one, write-one clears.
// - Block bit suppresses bus-zero power-event wakes in S5 only.
// - Wake follows enable and LAN override truth table; RTC reset clears block.
// - Trickle failure flag sets on supply failure or well power loss; write-one clears.
// - Stretch-after-power-up disable skips stretching after suspend power loss.
// - Suspend sleep output stretch skipped after G3 only, not DeepSx.
// - Lockdown freezes stretch disable, s3 width, s4 width and s4 stretch enable.
// - S3 width field selects 60 us, 1 ms, 50 ms or 2 s.
// - Host reset flag sets on host partition reset, write-one clears.
// - ESPI lock freezes enable and itself; only resume reset or platform reset clears it.
// - S4 width field codes 1 to 4 seconds; RTC reset forces 00.
// - After G3 or DeepSx, s4 minimum is timed from suspend reset release.
// - S4 stretch enable holds sleep_s4 asserted for the programmed minimum.
// - Periodic SMI every 64, 32, 16 or 8 seconds.
// - After G3 go to S0, or S5/S4-like when policy bit set.
// - In policy S5 only power button or preserved wake can wake.
// - Lockdown sets on every lock write strobe, which carries no data, and clears only on platform reset.
`timescale 1ns/10ps
`include "pm_sleep_defines.svh"
`default_nettype none
module pm_sleep_policy_status
    import pm_sleep_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `TICK_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Power and reset pins
    input wire logic resume_reset_pin_n,
    input wire logic rtc_reset_pin_n,
    input wire logic deep_sleep_well_power_good,
    input wire logic trickle_fail_pin,
    input wire logic host_reset_pin,
    // Register access
    input wire logic reg_wr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata_ff,
    input wire logic lock_wr,
    input wire logic espi_en_wr,
    input wire logic espi_en_wdata,
    output logic sleep_stretch_policy_lockdown_ff,
    output logic espi_smi_enable_bit_ff,
    // Sleep requests and pins, index s3 s4 aux lan sus
    input wire logic [`NCH-1:0] sleep_req,
    output logic [`NCH-1:0] sleep_out_n_ff,
    // Wake sources and policy
    input wire pwr_state_e pwr_state,
    input wire logic bus_zero_power_event_status,
    input wire logic bus_zero_power_event_enable,
    input wire logic wake_on_lan_override,
    input wire logic lan_wake,
    input wire logic power_button,
    input wire logic preserved_wake,
    input wire logic prev_in_s4,
    output logic wake_ff,
    output var g3_target_e g3_target_ff,
    // Periodic SMI
    output logic periodic_smi_ff
);
    logic [`NCH-1:0] sync1_ff, sync2_ff, pin_q_ff;
    logic rsm, rtc_ok, rsm_rise, host_rise;
    logic s4_viol_ff, sus_fail_ff, s5_block_ff, trickle_ff, dis_up_ff;
    logic host_rst_ff, espi_lock_ff, s4_str_ff, ag3_ff, ag3_s5_ff, deepsx_ff;
    logic [1:0] s3w_ff, s4w_ff, smi_sel_ff;
    logic [`DIV_W-1:0] div_ff;
    logic tick_ff;
    logic [`SMI_W-1:0] smi_cnt_ff, smi_per;
    logic [`CNT_W-1:0] cnt_ff [`NCH];
    logic [`CNT_W-1:0] s3min, s4min;
    logic [`NCH-1:0] req_q_ff, skip_ff, hold, nxt_act, act;
    logic wr_ok;
    logic nxt_wake;
    logic [31:0] nxt_rdata;

    // Pin synchronisers
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sync1_ff <= `SYNC_RST;
            sync2_ff <= `SYNC_RST;
            pin_q_ff <= `SYNC_RST;
        end else begin
            sync1_ff <= {host_reset_pin, trickle_fail_pin, deep_sleep_well_power_good,
                         rtc_reset_pin_n, resume_reset_pin_n};
            sync2_ff <= sync1_ff;
            pin_q_ff <= sync2_ff;
        end
    end
    assign rsm = sync2_ff[`PIN_RSM];
    assign rtc_ok = sync2_ff[`PIN_RTC];
    assign rsm_rise = rsm & ~pin_q_ff[`PIN_RSM];
    assign host_rise = sync2_ff[`PIN_HOST] & ~pin_q_ff[`PIN_HOST];
    assign wr_ok = reg_wr & ~sleep_stretch_policy_lockdown_ff;

    // Low-rate tick
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            div_ff <= '0;
            tick_ff <= 1'b0;
        end else if (div_ff == `DIV_W'(TICK_CYCLES - 1)) begin
            div_ff <= '0;
            tick_ff <= 1'b1;
        end else begin
            div_ff <= div_ff + 1'b1;
            tick_ff <= 1'b0;
        end
    end

    // Minimum width decode
    always_comb begin
        case (s3w_ff)
            2'h0: s3min = `CNT_W'(`US_TICKS(`S3W_0_US));
            2'h1: s3min = `CNT_W'(`US_TICKS(`S3W_1_MS * 1000));
            2'h2: s3min = `CNT_W'(`US_TICKS(`S3W_2_MS * 1000));
            default: s3min = `CNT_W'(`S_TICKS(`S3W_3_S));
        endcase
        case (s4w_ff)
            2'h3: s4min = `CNT_W'(`S_TICKS(`S4W_11_S));
            2'h2: s4min = `CNT_W'(`S_TICKS(`S4W_10_S));
            2'h1: s4min = `CNT_W'(`S_TICKS(`S4W_01_S));
            default: s4min = `CNT_W'(`S_TICKS(`S4W_00_S));
        endcase
    end

    assign act = ~sleep_out_n_ff;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            req_q_ff <= '0;
            deepsx_ff <= 1'b0;
        end else begin
            req_q_ff <= sleep_req;
            if (rsm) begin
                deepsx_ff <= act[`CH_SUS];
            end
        end
    end

    // Per-output width timers and stretching
    genvar ch;
    generate
        for (ch = 0; ch < `NCH; ch++) begin : g_ch
            logic [`CNT_W-1:0] min_w;
            logic str_en;
            assign min_w = (ch == `CH_S4) ? s4min : s3min;
            assign str_en = (ch == `CH_S4) ? s4_str_ff : 1'b1;
            assign hold[ch] = str_en & ~skip_ff[ch] & (cnt_ff[ch] < min_w);
            assign nxt_act[ch] = sleep_req[ch] | (act[ch] & hold[ch]);
            always_ff @(posedge sys_clk) begin
                if (!rst_n || !rsm) begin
                    cnt_ff[ch] <= '0;
                end else if (sleep_req[ch] && !req_q_ff[ch]) begin
                    cnt_ff[ch] <= '0;
                end else if (tick_ff && cnt_ff[ch] != {`CNT_W{1'b1}}) begin
                    cnt_ff[ch] <= cnt_ff[ch] + 1'b1;
                end
            end
            always_ff @(posedge sys_clk) begin
                if (!rst_n) begin
                    skip_ff[ch] <= 1'b0;
                end else if (rsm_rise) begin
                    skip_ff[ch] <= dis_up_ff & ((ch != `CH_SUS) | ~deepsx_ff);
                end else if (sleep_req[ch] && !req_q_ff[ch]) begin
                    skip_ff[ch] <= 1'b0;
                end
            end
            always_ff @(posedge sys_clk) begin
                if (!rst_n || !rsm) begin
                    sleep_out_n_ff[ch] <= 1'b0;
                end else begin
                    sleep_out_n_ff[ch] <= ~nxt_act[ch];
                end
            end
        end
    endgenerate

    // Status flags
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !rsm) begin
            s4_viol_ff <= 1'b0;
        end else if (act[`CH_S4] && !nxt_act[`CH_S4] && cnt_ff[`CH_S4] < s4min) begin
            s4_viol_ff <= 1'b1;
        end else if (reg_wr && reg_wdata[`B_S4_VIOL]) begin
            s4_viol_ff <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sus_fail_ff <= `SUS_FAIL_RST;
        end else if (!rsm) begin
            sus_fail_ff <= 1'b1;
        end else if (reg_wr && reg_wdata[`B_SUS_FAIL]) begin
            sus_fail_ff <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            trickle_ff <= `TRICKLE_RST;
        end else if (!sync2_ff[`PIN_DSW] || sync2_ff[`PIN_TRK]) begin
            trickle_ff <= 1'b1;
        end else if (reg_wr && reg_wdata[`B_TRICKLE]) begin
            trickle_ff <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            host_rst_ff <= 1'b0;
        end else if (host_rise) begin
            host_rst_ff <= 1'b1;
        end else if (reg_wr && reg_wdata[`B_HOST_RST]) begin
            host_rst_ff <= 1'b0;
        end
    end

    // Resume-well policy fields
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !rsm) begin
            s3w_ff <= 2'h0;
            espi_lock_ff <= 1'b0;
            espi_smi_enable_bit_ff <= 1'b0;
        end else begin
            if (wr_ok) begin
                s3w_ff <= reg_wdata[`F_S3W];
            end
            if (reg_wr && reg_wdata[`B_ESPI_LOCK]) begin
                espi_lock_ff <= 1'b1;
            end
            if (espi_en_wr && !espi_lock_ff) begin
                espi_smi_enable_bit_ff <= espi_en_wdata;
            end
        end
    end

    // RTC-well policy fields
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !rtc_ok) begin
            s5_block_ff <= 1'b0;
            dis_up_ff <= 1'b0;
            s4w_ff <= `S4W_RST;
            s4_str_ff <= 1'b0;
            ag3_ff <= 1'b0;
        end else if (reg_wr) begin
            s5_block_ff <= reg_wdata[`B_S5_BLOCK];
            ag3_ff <= reg_wdata[`B_AG3];
            if (wr_ok) begin
                dis_up_ff <= reg_wdata[`B_DIS_UP];
                s4w_ff <= reg_wdata[`F_S4W];
                s4_str_ff <= reg_wdata[`B_S4_STR];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            smi_sel_ff <= 2'h0;
        end else if (reg_wr) begin
            smi_sel_ff <= reg_wdata[`F_SMI];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sleep_stretch_policy_lockdown_ff <= 1'b0;
        end else if (lock_wr) begin
            sleep_stretch_policy_lockdown_ff <= 1'b1;
        end
    end

    // Periodic SMI
    always_comb begin
        case (smi_sel_ff)
            2'h0: smi_per = `SMI_W'(`S_TICKS(`SMI_00_S));
            2'h1: smi_per = `SMI_W'(`S_TICKS(`SMI_01_S));
            2'h2: smi_per = `SMI_W'(`S_TICKS(`SMI_10_S));
            default: smi_per = `SMI_W'(`S_TICKS(`SMI_11_S));
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            smi_cnt_ff <= '0;
            periodic_smi_ff <= 1'b0;
        end else if (tick_ff && smi_cnt_ff >= smi_per - 1'b1) begin
            smi_cnt_ff <= '0;
            periodic_smi_ff <= 1'b1;
        end else begin
            if (tick_ff) begin
                smi_cnt_ff <= smi_cnt_ff + 1'b1;
            end
            periodic_smi_ff <= 1'b0;
        end
    end

    // After-G3 state and wake decision
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            g3_target_ff <= TGT_S0;
            ag3_s5_ff <= 1'b0;
        end else if (rsm_rise) begin
            g3_target_ff <= !ag3_ff ? TGT_S0 : (prev_in_s4 ? TGT_S4 : TGT_S5);
            ag3_s5_ff <= ag3_ff;
        end else if (pwr_state == PS_S0) begin
            ag3_s5_ff <= 1'b0;
        end
    end

    always_comb begin
        nxt_wake = 1'b0;
        case (pwr_state)
            PS_S1, PS_S3, PS_S4: begin
                nxt_wake = power_button | (bus_zero_power_event_enable & bus_zero_power_event_status);
            end
            PS_S5: begin
                if (ag3_s5_ff) begin
                    nxt_wake = power_button | preserved_wake;
                end else begin
                    nxt_wake = power_button | (wake_on_lan_override & lan_wake)
                        | (bus_zero_power_event_enable & ~s5_block_ff & bus_zero_power_event_status);
                end
            end
            default: nxt_wake = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wake_ff <= 1'b0;
        end else begin
            wake_ff <= nxt_wake;
        end
    end

    // Register readback
    always_comb begin
        nxt_rdata = '0;
        nxt_rdata[`B_S4_VIOL] = s4_viol_ff;
        nxt_rdata[`B_SUS_FAIL] = sus_fail_ff;
        nxt_rdata[`B_S5_BLOCK] = s5_block_ff;
        nxt_rdata[`B_TRICKLE] = trickle_ff;
        nxt_rdata[`B_DIS_UP] = dis_up_ff;
        nxt_rdata[`F_S3W] = s3w_ff;
        nxt_rdata[`B_HOST_RST] = host_rst_ff;
        nxt_rdata[`B_ESPI_LOCK] = espi_lock_ff;
        nxt_rdata[`F_S4W] = s4w_ff;
        nxt_rdata[`B_S4_STR] = s4_str_ff;
        nxt_rdata[`F_SMI] = smi_sel_ff;
        nxt_rdata[`B_AG3] = ag3_ff;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            reg_rdata_ff <= '0;
        end else begin
            reg_rdata_ff <= nxt_rdata;
        end
    end

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_viol_short_set: assert property (
        rsm && act[`CH_S4] && !nxt_act[`CH_S4] && cnt_ff[`CH_S4] < s4min |=> s4_viol_ff)
        else $error("short s4 assertion not flagged");
    a_sus_fail_set: assert property (
        !rsm |=> sus_fail_ff && !s4_viol_ff)
        else $error("resume reset did not set power failure");
    a_lock_freezes: assert property (
        sleep_stretch_policy_lockdown_ff && rtc_ok |=> $stable(s4w_ff) && $stable(s4_str_ff) && $stable(dis_up_ff))
        else $error("locked stretch field changed");
    a_s4_hold: assert property (
        rsm && act[`CH_S4] && s4_str_ff && !skip_ff[`CH_S4] && cnt_ff[`CH_S4] < s4min |=> !sleep_out_n_ff[`CH_S4])
        else $error("sleep_s4 released early");
    a_espi_locked: assert property (
        espi_lock_ff && rsm |=> $stable(espi_smi_enable_bit_ff) && espi_lock_ff)
        else $error("locked espi enable changed");
    a_s5_blocked: assert property (
        pwr_state == PS_S5 && s5_block_ff && !ag3_s5_ff && !power_button && !lan_wake |=> !wake_ff)
        else $error("blocked S5 wake occurred");
    a_smi_on_tick: assert property (
        periodic_smi_ff |-> $past(tick_ff) && smi_cnt_ff == '0)
        else $error("periodic SMI outside terminal count");
    a_rtc_clears: assert property (
        !rtc_ok |=> s4w_ff == `S4W_RST && !s5_block_ff && !ag3_ff && !s4_str_ff)
        else $error("RTC reset did not clear fields");
    a_host_flag_set: assert property (
        host_rise |=> host_rst_ff)
        else $error("host reset not recorded");
    a_g3_boot_s0: assert property (
        rsm_rise && !ag3_ff |=> g3_target_ff == TGT_S0)
        else $error("wrong after-G3 target");
    a_trickle_set: assert property (
        !sync2_ff[`PIN_DSW] |=> trickle_ff)
        else $error("trickle flag not set");
    a_lock_sticky: assert property (
        sleep_stretch_policy_lockdown_ff |=> sleep_stretch_policy_lockdown_ff)
        else $error("lockdown cleared without reset");
endmodule // pm_sleep_policy_status
`default_nettype wire

// ==== testbench/pm_power_supply_model.sv ====
// Platform supply and reset pin model that drives the block's power pins
`timescale 1ns/10ps
`include "pm_sleep_defines.svh"
`default_nettype none
module pm_power_supply_model (
    // Clock
    input wire logic sys_clk,
    // Power and reset pins
    output logic resume_reset_pin_n,
    output logic rtc_reset_pin_n,
    output logic deep_sleep_well_power_good,
    output logic trickle_fail_pin,
    output logic host_reset_pin
);
    logic [4:0] act_ff = 5'h00;
    assign resume_reset_pin_n = ~act_ff[`PIN_RSM];
    assign rtc_reset_pin_n = ~act_ff[`PIN_RTC];
    assign deep_sleep_well_power_good = ~act_ff[`PIN_DSW];
    assign trickle_fail_pin = act_ff[`PIN_TRK];
    assign host_reset_pin = act_ff[`PIN_HOST];
    // Hold one pin active for n cycles, changing only after rising edges
    task automatic pulse(input int idx, input int n);
        @(posedge sys_clk);
        act_ff[idx] <= 1'b1;
        repeat (n) @(posedge sys_clk);
        act_ff[idx] <= 1'b0;
    endtask
endmodule // pm_power_supply_model
`default_nettype wire

// ==== testbench/test_pm_sleep_policy_status.sv ====
// Self-checking bench of the sleep policy and status block
`timescale 1ns/10ps
`include "pm_sleep_defines.svh"
`default_nettype none
module test_pm_sleep_policy_status
    import pm_sleep_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    wire logic rsm_n, rtc_n, dsw_good, trk, host;
    logic reg_wr = 1'b0;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] rdata;
    logic lock_wr = 1'b0;
    logic es_wr = 1'b0;
    logic es_wd = 1'b0;
    logic lockdown, espi_en, wake, smi;
    logic [`NCH-1:0] req = 5'h1F;
    logic [`NCH-1:0] out_n;
    pwr_state_e pwr_state = PS_S0;
    pwr_state_e st [5] = '{PS_S0, PS_S1, PS_S3, PS_S4, PS_S5};
    g3_target_e g3t;
    logic sts = 1'b0, en = 1'b0, ov = 1'b0, lan = 1'b0, pres = 1'b0, prev4 = 1'b0, pb = 1'b0;
    int n_fail = 0;
    int n_smi = 0;
    int checks_done = 0;
    int i, b, s, k, p;
    logic e;

    always #10 sys_clk = ~sys_clk;

    // Counts periodic SMI pulses; none may come within the short run
    always @(posedge sys_clk) begin
        if (smi === 1'b1) begin
            n_smi++;
        end
    end

    pm_power_supply_model i_psu (.sys_clk(sys_clk), .resume_reset_pin_n(rsm_n), .rtc_reset_pin_n(rtc_n),
        .deep_sleep_well_power_good(dsw_good), .trickle_fail_pin(trk), .host_reset_pin(host));

    pm_sleep_policy_status #(.TICK_CYCLES(2)) i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .resume_reset_pin_n(rsm_n), .rtc_reset_pin_n(rtc_n), .deep_sleep_well_power_good(dsw_good),
        .trickle_fail_pin(trk), .host_reset_pin(host), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rdata_ff(rdata), .lock_wr(lock_wr), .espi_en_wr(es_wr), .espi_en_wdata(es_wd),
        .sleep_stretch_policy_lockdown_ff(lockdown), .espi_smi_enable_bit_ff(espi_en),
        .sleep_req(req), .sleep_out_n_ff(out_n), .pwr_state(pwr_state),
        .bus_zero_power_event_status(sts), .bus_zero_power_event_enable(en),
        .wake_on_lan_override(ov), .lan_wake(lan), .power_button(pb), .preserved_wake(pres),
        .prev_in_s4(prev4), .wake_ff(wake), .g3_target_ff(g3t), .periodic_smi_ff(smi));

    task automatic finish_test();
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        checks_done++;
        if (g !== x) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, g, x);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // Write the word, then compare the readback two edges later
    task automatic wx(input logic [31:0] d, input logic [31:0] x);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        settle(2);
        chk(rdata, x);
    endtask

    task automatic pin(input int idx, input logic [31:0] x);
        i_psu.pulse(idx, 4);
        settle(8);
        chk(rdata, x);
    endtask

    task automatic es(input logic v, input logic x);
        @(posedge sys_clk);
        es_wr <= 1'b1;
        es_wd <= v;
        @(posedge sys_clk);
        es_wr <= 1'b0;
        settle(2);
        chk(32'(espi_en), 32'(x));
    endtask

    task automatic sreq(input int idx, input logic v, input int n);
        @(posedge sys_clk);
        req[idx] <= v;
        settle(n);
    endtask

    initial begin
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        settle(8);
        chk(rdata, 32'h00014000);
        wx(32'h00014000, 32'h0);
        pin(`PIN_TRK, 32'h00004000);
        wx(32'h00004000, 32'h0);
        pin(`PIN_DSW, 32'h00004000);
        wx(32'h00004000, 32'h0);
        pin(`PIN_HOST, 32'h00000200);
        wx(32'h0, 32'h00000200);
        wx(32'h00000200, 32'h0);
        es(1'b1, 1'b1);
        wx(32'h00009D3F, 32'h00009D3F);
        es(1'b0, 1'b1);
        wx(32'h0, 32'h00000100);
        wx(32'h00009D3F, 32'h00009D3F);
        pin(`PIN_RTC, 32'h00000D06);
        pin(`PIN_RSM, 32'h00010006);
        chk(32'(espi_en), 32'h0);
        chk(32'(g3t), 32'(TGT_S0));
        wx(32'h00010006, 32'h00000006);
        for (p = 0; p < 2; p++) begin
            @(posedge sys_clk);
            prev4 <= p[0];
            pwr_state <= PS_S5;
            wx(32'h1, p ? 32'h00010001 : 32'h1);
            i_psu.pulse(`PIN_RSM, 4);
            settle(8);
            chk(32'(g3t), p ? 32'(TGT_S4) : 32'(TGT_S5));
            if (p == 0) begin
                @(posedge sys_clk);
                ov <= 1'b1;
                lan <= 1'b1;
                settle(3);
                chk(32'(wake), 32'h0);
                @(posedge sys_clk);
                pres <= 1'b1;
                settle(3);
                chk(32'(wake), 32'h1);
                @(posedge sys_clk);
                pres <= 1'b0;
                pb <= 1'b1;
                settle(3);
                chk(32'(wake), 32'h1);
                @(posedge sys_clk);
                pb <= 1'b0;
                ov <= 1'b0;
            end
        end
        // Wake decision over states, enable and LAN override, block off and on
        for (b = 0; b < 2; b++) begin
            wx(32'h00010000 | (32'(b) << 15), 32'(b) << 15);
            for (s = 0; s < 5; s++) begin
                for (k = 0; k < 4; k++) begin
                    @(posedge sys_clk);
                    pwr_state <= st[s];
                    en <= k[0];
                    ov <= k[1];
                    sts <= 1'b1;
                    lan <= 1'b1;
                    settle(3);
                    e = (s == 0) ? 1'b0 : (s == 4) ? (k[1] | (k[0] & ~b[0])) : k[0];
                    chk(32'(wake), 32'(e));
                end
            end
        end
        @(posedge sys_clk);
        pwr_state <= PS_S0;
        wx(32'h0, 32'h0);
        sreq(0, 1'b0, 40);
        sreq(0, 1'b1, 0);
        sreq(0, 1'b0, 3);
        chk(32'(out_n[0]), 32'h0);
        for (i = 0; i < 40 && out_n[0] !== 1'b1; i++) begin
            settle(1);
        end
        chk(32'(i >= 4 && i < 40), 32'h1);
        chk(32'(out_n[4:2]), 32'h0);
        sreq(1, 1'b0, 3);
        sreq(1, 1'b1, 3);
        sreq(1, 1'b0, 6);
        chk(32'(rdata[18]), 32'h1);
        wx(32'h00040000, 32'h0);
        wx(32'h00000008, 32'h00000008);
        sreq(1, 1'b1, 3);
        sreq(1, 1'b0, 6);
        chk(32'(out_n[1]), 32'h0);
        @(posedge sys_clk);
        lock_wr <= 1'b1;
        @(posedge sys_clk);
        lock_wr <= 1'b0;
        settle(2);
        chk(32'(lockdown), 32'h1);
        wx(32'h00041C37, 32'h0000000F);
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        settle(3);
        chk(32'(lockdown), 32'h0);
        chk(rdata, 32'h00054000);
        chk(32'(n_smi), 32'h0);
        finish_test();
    end
endmodule // test_pm_sleep_policy_status
`default_nettype wire
